// ===== hw/odspi_cfg.svh
// timing and field constants for the octal driver serial slave
`ifndef ODSPI_CFG_SVH
`define ODSPI_CFG_SVH
`define ODSPI_CH_N         8
`define ODSPI_FRAME8_BITS  8
`define ODSPI_FRAME16_BITS 16
`define ODSPI_CMD_SET_OUT  7'h00
`define ODSPI_CMD_SET_PP   7'h01
`define ODSPI_CMD_SET_OL   7'h02
`define ODSPI_CMD_SET_CFG  7'h03
`define ODSPI_CMD_READ     7'h20
`define ODSPI_CMD_STATUS   7'h30
`define ODSPI_REG_OL       3'h4
`define ODSPI_REG_TH       3'h5
`define ODSPI_REG_GLOB     3'h6
`define ODSPI_REG_OV       3'h7
`define ODSPI_RST_BYTE     8'h00
`define ODSPI_CLKERR_BIT   4
`endif

// ===== hw/odspi_pkg.sv
// types shared by the octal driver serial slave
package odspi_pkg;
  typedef enum logic [1:0] {
    ODSPI_DIRECT8,
    ODSPI_DIRECT16,
    ODSPI_COMMAND
  } odspi_mode_type;

  typedef struct packed {
    logic [7:0] open_load;
    logic [7:0] thermal;
    logic [7:0] global_flt;
    logic [7:0] above_7v;
    logic [7:0] slow_mode;
    logic [7:0] overvolt;
    logic       global_fault;
  } odspi_status_type;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] push_pull;
    logic [7:0] open_load_en;
    logic [7:0] config_reg;
  } odspi_settings_type;

  typedef struct packed {
    logic [7:0] open_load;
    logic [7:0] thermal;
    logic [7:0] global_flt;
  } odspi_faults_type;
endpackage : odspi_pkg

// ===== hw/odspi_sync.sv
// two flip-flop synchroniser for the serial pins
module odspi_sync (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } odspi_sync_state_type;

  odspi_sync_state_type state_q;
  odspi_sync_state_type state_d;

  always_comb
  begin
    state_d.meta   = async_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign sync_out = state_q.stable;
endmodule : odspi_sync

// ===== hw/odspi_flt_latch.sv
// sticky fault registers, set wins over clear
module odspi_flt_latch (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      enable,
  input  wire odspi_pkg::odspi_faults_type live,
  input  wire logic                      clear,
  output odspi_pkg::odspi_faults_type    latched
);
  odspi_pkg::odspi_faults_type state_q;
  odspi_pkg::odspi_faults_type state_d;

  always_comb
  begin
    state_d = clear ? '0 : state_q;
    if (enable)
      state_d = state_d | live; // R18
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign latched = state_q;

  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    enable && !clear && state_q.thermal[0] |=> state_q.thermal[0]) // R18
    else $error("latched fault dropped without clear");
  set_wins_a: assert property (@(posedge sys_clk) disable iff (srst)
    enable && live.open_load[0] |=> state_q.open_load[0]) // R18
    else $error("live fault not latched");
endmodule : odspi_flt_latch

// ===== hw/odspi_slave.sv
// serial control and diagnostics slave of the octal output driver
// Operation
// R1 - sample input on rise, shift on fall
// R2 - master idles clock low
// R3 - output driven only during chip-select low
// R4 - output settings applied at frame end
// R5 - status snapshot at frame start
// R6 - direct mode needs serial setting pin
// R7 - direct 8-bit framing select
// R8 - direct 16-bit framing select
// R9 - 8-bit data sets level or mode
// R10 - direct modes return per-channel fault
// R11 - 16-bit level plus driver mode
// R12 - 16-bit config pairs, levels kept
// R13 - 16-bit status: above 7v or slow
// R14 - parallel mode uses input pins
// R15 - command frames are sixteen bits
// R16 - command answer follows previous command
// R17 - parallel command config only on variant
// R18 - fault bits latch on live fault; code latches only while mode is ODSPI_COMMAND
// R19 - clear bit clears all fault registers
// R20 - global fault latched in serial command
// R21 - daisy chain echoes input frame later
// R22 - clear at frame end unless error
// R23 - command byte decode
// R24 - read register command returns value
// R25 - msb first, exact clock count
module odspi_slave (
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  input  wire logic                         spi_clk,
  input  wire logic                         spi_cs_n,
  input  wire logic                         spi_sdi,
  output logic                              spi_sdo,
  output logic                              spi_sdo_oe_n,
  input  wire logic                         serial_setting_select,
  input  wire logic                         command_mode_select,
  input  wire logic                         config_select,
  input  wire logic                         frame16_select,
  input  wire logic                         global_openload_enable,
  input  wire logic                         parallel_config_allowed,
  input  wire logic [7:0]                   parallel_in,
  input  wire odspi_pkg::odspi_status_type  live_status,
  output logic [7:0]                        high_side_switch,
  output logic [7:0]                        low_side_switch,
  output logic [7:0]                        push_pull,
  output logic [7:0]                        open_load,
  output logic [7:0]                        config_out,
  output logic                              global_fault_n,
  output logic                              frame_error
);
  `include "odspi_cfg.svh"

  typedef struct packed {
    logic                          clk_prev;
    logic                          cs_prev;
    logic                          active;
    odspi_pkg::odspi_mode_type     mode;
    logic [4:0]                    count;
    logic [15:0]                   rx;
    logic [15:0]                   tx;
    logic [15:0]                   echo;
    logic                          sdo;
    logic                          sdo_oe_n;
    logic                          first_echo;
    logic [6:0]                    last_cmd;
    logic [2:0]                    last_idx;
    odspi_pkg::odspi_settings_type set;
    logic                          gflt_latch;
    logic                          ferr;
    logic [7:0]                    hs;
    logic [7:0]                    ls;
    logic [7:0]                    pp_out;
    logic [7:0]                    ol_out;
    logic                          gflt_n;
  } odspi_state_type;

  odspi_state_type state_q;
  odspi_state_type state_d;
  logic            clk_s;
  logic            cs_s;
  logic            sdi_s;
  logic            clear_pulse;
  odspi_pkg::odspi_faults_type live_faults;
  odspi_pkg::odspi_faults_type latched;

  odspi_sync u_sync_clk (.sys_clk(sys_clk), .srst(srst), .async_in(spi_clk),  .sync_out(clk_s));
  odspi_sync u_sync_cs  (.sys_clk(sys_clk), .srst(srst), .async_in(spi_cs_n), .sync_out(cs_s));
  odspi_sync u_sync_sdi (.sys_clk(sys_clk), .srst(srst), .async_in(spi_sdi),  .sync_out(sdi_s));

  assign live_faults.open_load  = live_status.open_load;
  assign live_faults.thermal    = live_status.thermal;
  assign live_faults.global_flt = live_status.global_flt;

  odspi_flt_latch u_latch (
    .sys_clk (sys_clk),
    .srst    (srst),
    .enable  (state_q.mode == odspi_pkg::ODSPI_COMMAND),
    .live    (live_faults),
    .clear   (clear_pulse),
    .latched (latched)
  );

  function automatic odspi_pkg::odspi_mode_type pick_mode(input logic ser, input logic cmd,
                                                          input logic f16);
    if (cmd || !ser)
      pick_mode = odspi_pkg::ODSPI_COMMAND; // R6 R15
    else if (f16)
      pick_mode = odspi_pkg::ODSPI_DIRECT16; // R8
    else
      pick_mode = odspi_pkg::ODSPI_DIRECT8; // R7
  endfunction : pick_mode

  function automatic logic [4:0] frame_len(input odspi_pkg::odspi_mode_type m);
    frame_len = (m == odspi_pkg::ODSPI_DIRECT8) ? 5'(`ODSPI_FRAME8_BITS)
                                                 : 5'(`ODSPI_FRAME16_BITS);
  endfunction : frame_len

  logic        cs_fall;
  logic        cs_rise;
  logic        clk_rise;
  logic        clk_fall;
  logic [7:0]  fault_rt;
  logic [7:0]  level_rt;
  logic        cfg_ok;
  logic        good;

  always_comb
  begin
    state_d     = state_q;
    clear_pulse = 1'b0;
    cs_fall     = state_q.cs_prev && !cs_s;
    cs_rise     = !state_q.cs_prev && cs_s;
    clk_rise    = !state_q.clk_prev && clk_s && !cs_s;
    clk_fall    = state_q.clk_prev && !clk_s && !cs_s;
    fault_rt    = live_status.thermal | live_status.open_load; // R10
    level_rt    = config_select ? live_status.slow_mode : live_status.above_7v; // R13
    cfg_ok      = serial_setting_select || parallel_config_allowed; // R17
    good        = state_q.count == frame_len(state_q.mode); // R25
    state_d.clk_prev = clk_s;
    state_d.cs_prev  = cs_s;

    if (cs_fall)
    begin
      state_d.active     = 1'b1;
      state_d.mode       = pick_mode(serial_setting_select, command_mode_select,
                                     frame16_select);
      state_d.count      = '0;
      state_d.sdo_oe_n   = 1'b0; // R3
      state_d.first_echo = 1'b1;
      // snapshot of status for this frame
      if (state_d.mode == odspi_pkg::ODSPI_DIRECT8)
        state_d.tx = {fault_rt, 8'h00}; // R5 R10
      else if (state_d.mode == odspi_pkg::ODSPI_DIRECT16)
        state_d.tx = {fault_rt, level_rt}; // R5 R13
      else if (state_q.last_cmd == `ODSPI_CMD_READ)
      begin
        case (state_q.last_idx) // R16 R24
          3'h0:            state_d.tx = {8'h00, state_q.set.level};
          3'h1:            state_d.tx = {8'h00, state_q.set.push_pull};
          3'h2:            state_d.tx = {8'h00, state_q.set.open_load_en};
          3'h3:            state_d.tx = {8'h00, state_q.set.config_reg};
          `ODSPI_REG_OL:   state_d.tx = {live_status.open_load, latched.open_load};
          `ODSPI_REG_TH:   state_d.tx = {live_status.thermal, latched.thermal};
          `ODSPI_REG_GLOB: state_d.tx = {live_status.global_flt, latched.global_flt};
          default:         state_d.tx = {live_status.overvolt, 8'h00};
        endcase
      end
      else
        state_d.tx = {fault_rt, level_rt}; // R16
      state_d.sdo = state_d.tx[15];
      state_d.tx  = {state_d.tx[14:0], 1'b0};
    end

    if (state_q.active && clk_rise)
    begin
      state_d.rx    = {state_q.rx[14:0], sdi_s}; // R1 R25
      // saturate so an overlong frame never wraps back to a legal count
      if (state_q.count != '1)
        state_d.count = state_q.count + 5'h01;
    end

    if (state_q.active && clk_fall)
    begin
      // after one full frame the chain echo replaces the status
      if (state_q.count == frame_len(state_q.mode) && state_q.first_echo)
      begin
        state_d.first_echo = 1'b0;
        state_d.echo       = (state_q.mode == odspi_pkg::ODSPI_DIRECT8) ?
                             {state_q.rx[7:0], 8'h00} : state_q.rx; // R21
      end
      if (state_q.count >= frame_len(state_q.mode))
      begin
        state_d.sdo  = state_d.echo[15]; // R21
        state_d.echo = {state_d.echo[14:0], 1'b0};
      end
      else
      begin
        state_d.sdo = state_q.tx[15]; // R1 R5
        state_d.tx  = {state_q.tx[14:0], 1'b0};
      end
    end

    if (cs_rise && state_q.active)
    begin
      state_d.active   = 1'b0;
      state_d.sdo_oe_n = 1'b1; // R3
      state_d.sdo      = 1'b0;
      state_d.ferr     = !good;
      if (good)
      begin
        case (state_q.mode)
          odspi_pkg::ODSPI_DIRECT8:
          begin
            if (config_select)
              state_d.set.push_pull = state_q.rx[7:0]; // R9
            else
              state_d.set.level = state_q.rx[7:0]; // R4 R9
          end
          odspi_pkg::ODSPI_DIRECT16:
          begin
            for (int i = 0; i < 8; i++)
            begin
              if (!config_select)
              begin
                state_d.set.level[i]     = state_q.rx[2*i+1]; // R4 R11
                state_d.set.push_pull[i] = state_q.rx[2*i]; // R11
              end
              else if (state_q.rx[2*i+1 -: 2] != 2'b11)
              begin
                state_d.set.push_pull[i]    = state_q.rx[2*i]; // R12
                state_d.set.open_load_en[i] = state_q.rx[2*i+1]; // R12
              end
            end
          end
          default:
          begin
            state_d.last_cmd = state_q.rx[14:8]; // R23
            state_d.last_idx = state_q.rx[2:0]; // R24
            clear_pulse      = state_q.rx[15]; // R19 R22
            case (state_q.rx[14:8]) // R23
              `ODSPI_CMD_SET_OUT: state_d.set.level = state_q.rx[7:0];
              `ODSPI_CMD_SET_PP:
                if (cfg_ok) state_d.set.push_pull = state_q.rx[7:0]; // R17
              `ODSPI_CMD_SET_OL:
                if (cfg_ok) state_d.set.open_load_en = state_q.rx[7:0]; // R17
              `ODSPI_CMD_SET_CFG:
                if (cfg_ok) state_d.set.config_reg = state_q.rx[7:0]; // R17
              default: ;
            endcase
            if (state_q.rx[15])
              state_d.gflt_latch = 1'b0;
          end
        endcase
      end
    end

    // global fault latched only in serial command mode
    if (serial_setting_select && command_mode_select)
      state_d.gflt_latch = state_d.gflt_latch | live_status.global_fault; // R20
    else
      state_d.gflt_latch = live_status.global_fault; // R20

    // drivers: serial level follows the frame-end settings, parallel level follows parallel_in
    for (int i = 0; i < 8; i++)
    begin
      logic lvl;
      logic ppm;
      lvl = serial_setting_select ? state_q.set.level[i] : parallel_in[i]; // R14
      ppm = state_q.set.push_pull[i];
      state_d.hs[i]     = lvl; // R4
      state_d.ls[i]     = !lvl && ppm; // R9 R11
      state_d.pp_out[i] = ppm;
      state_d.ol_out[i] = !ppm && (state_q.set.open_load_en[i] || global_openload_enable);
    end
    state_d.gflt_n = !state_q.gflt_latch;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q          <= '0;
      state_q.sdo_oe_n <= 1'b1;
      state_q.gflt_n   <= 1'b1;
      state_q.mode     <= odspi_pkg::ODSPI_DIRECT8;
    end
    else
      state_q <= state_d;
  end

  assign spi_sdo          = state_q.sdo;
  assign spi_sdo_oe_n     = state_q.sdo_oe_n;
  assign high_side_switch = state_q.hs;
  assign low_side_switch  = state_q.ls;
  assign push_pull        = state_q.pp_out;
  assign open_load        = state_q.ol_out;
  assign config_out       = state_q.set.config_reg;
  assign global_fault_n   = state_q.gflt_n;
  assign frame_error      = state_q.ferr;

  sequence frame_open_s;
    state_q.cs_prev && !cs_s;
  endsequence
  sequence frame_close_s;
    !state_q.cs_prev && cs_s && state_q.active;
  endsequence

  drive_window_a: assert property (@(posedge sys_clk) disable iff (srst)
    frame_close_s |=> spi_sdo_oe_n) // R3
    else $error("sdo still driven after frame");
  drive_start_a: assert property (@(posedge sys_clk) disable iff (srst)
    frame_open_s |=> !spi_sdo_oe_n) // R3
    else $error("sdo not driven in frame");
  level_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    state_q.active && !cs_rise && serial_setting_select |=> $stable(state_q.set.level)) // R4
    else $error("level changed mid frame");
  bad_count_a: assert property (@(posedge sys_clk) disable iff (srst)
    frame_close_s ##0 (state_q.count != frame_len(state_q.mode)) |=> frame_error) // R25
    else $error("clock count error not flagged");
  no_clear_err_a: assert property (@(posedge sys_clk) disable iff (srst)
    frame_close_s ##0 !good |-> !clear_pulse) // R22
    else $error("clear on errored frame");
  mode_pick_a: assert property (@(posedge sys_clk) disable iff (srst)
    frame_open_s ##0 !serial_setting_select |=>
      state_q.mode == odspi_pkg::ODSPI_COMMAND) // R6
    else $error("direct mode without serial setting");
  gflt_latched_a: assert property (@(posedge sys_clk) disable iff (srst)
    serial_setting_select && command_mode_select && state_q.gflt_latch &&
      !(cs_rise && state_q.active)
      |=> state_q.gflt_latch) // R20
    else $error("global fault latch dropped");
  push_pull_ls_a: assert property (@(posedge sys_clk) disable iff (srst)
    ##1 (high_side_switch & low_side_switch) == 8'h00) // R9
    else $error("both switches on");
endmodule : odspi_slave

// ===== verification/odspi_master.sv
// serial master model: mode 0 frames, msb first
module odspi_master (
  output logic     spi_clk,
  output logic     spi_cs_n,
  output logic     spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n
);
  timeunit 1ns;
  timeprecision 10ps;
  int oe_bad = 0;
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // n clocks of 125 ns; rx collects what came back
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    spi_cs_n = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_sdi = tx[i];
      #31.25;
      spi_clk = 1'b1;
      rx = {rx[30:0], spi_sdo};
      if (spi_sdo_oe_n !== 1'b0)
        oe_bad++;
      #62.5;
      spi_clk = 1'b0;
      #31.25;
    end
    #31.25;
    spi_cs_n = 1'b1;
    // released data line shows no stale bit
    spi_sdi = ~spi_sdi;
  endtask : xfer
endmodule : odspi_master

// ===== verification/octal_driver_spi_slave_tb.sv
// self-checking bench of the octal driver serial slave
module octal_driver_spi_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic spi_clk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n, sdo_pin;
  logic serial_setting_select, command_mode_select, config_select, frame16_select;
  logic global_openload_enable, parallel_config_allowed, global_fault_n, frame_error;
  logic [7:0] parallel_in, high_side_switch, low_side_switch, push_pull, open_load, config_out;
  odspi_pkg::odspi_status_type live_status;
  logic [31:0] rx, w;
  logic [7:0] lvl, pp, f, d;
  int rg [4];
  int n_errors, tests_run;

  always #5 sys_clk = ~sys_clk;
  // weak pull-down while released
  assign sdo_pin = spi_sdo_oe_n ? 1'b0 : spi_sdo;

  odspi_slave DUT (.sys_clk, .srst, .spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
    .serial_setting_select, .command_mode_select, .config_select, .frame16_select,
    .global_openload_enable, .parallel_config_allowed, .parallel_in, .live_status,
    .high_side_switch, .low_side_switch, .push_pull, .open_load, .config_out,
    .global_fault_n, .frame_error);
  odspi_master m (.spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo(sdo_pin), .spi_sdo_oe_n);

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic fr(input int n, input logic [31:0] tx);
    m.xfer(n, tx, rx);
    repeat (12) @(negedge sys_clk);
  endtask : fr

  task automatic drv;
    chk(high_side_switch, lvl);
    chk(low_side_switch, ~lvl & pp);
    chk(push_pull, pp);
    chk(spi_sdo_oe_n, 1'b1);
  endtask : drv

  task automatic md(input logic [3:0] s);
    {serial_setting_select, command_mode_select, config_select, frame16_select} = s;
    @(negedge sys_clk);
  endtask : md

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial
  begin
    #200000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    {serial_setting_select, command_mode_select, config_select, frame16_select} = 4'h8;
    global_openload_enable = 1'b0;
    parallel_config_allowed = 1'b0;
    parallel_in = 8'h00;
    live_status = '0;
    lvl = 8'h00;
    pp = 8'h00;
    void'($urandom(11));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({spi_sdo_oe_n, global_fault_n, frame_error, spi_sdo}, 4'hc);
    drv();
    $display("reset test done");

    for (int k = 0; k < 4; k++)
    begin
      d = 8'($urandom);
      live_status.open_load = 8'($urandom);
      live_status.thermal = 8'($urandom);
      f = live_status.open_load | live_status.thermal;
      fork
        fr(8, {24'h0, d});
        #300 live_status.thermal = ~live_status.thermal;
      join
      chk(rx[7:0], f);
      lvl = d;
      drv();
    end
    md(4'ha);
    d = 8'($urandom);
    fr(8, {24'h0, d});
    pp = d;
    drv();
    $display("direct 8-bit test done");

    md(4'h9);
    live_status.above_7v = 8'($urandom);
    f = live_status.open_load | live_status.thermal;
    w = $urandom;
    fr(16, {16'h0, w[15:0]});
    for (int i = 0; i < 8; i++)
    begin
      lvl[i] = w[2 * i + 1];
      pp[i] = w[2 * i];
    end
    chk(rx[15:0], {f, live_status.above_7v});
    drv();
    fr(8, 32'hff);
    chk(frame_error, 1'b1);
    drv();
    md(4'hb);
    live_status.slow_mode = 8'($urandom);
    for (int i = 0; i < 8; i++)
    begin
      w[2 * i +: 2] = 2'(i % 4);
      if (i % 4 < 3)
        pp[i] = (i % 4 == 1);
    end
    fr(16, {16'h0, w[15:0]});
    chk(rx[15:0], {f, live_status.slow_mode});
    chk(frame_error, 1'b0);
    drv();
    chk(open_load & 8'h55, 8'h44);
    global_openload_enable = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(open_load & 8'h55, 8'h55);
    global_openload_enable = 1'b0;
    w = $urandom;
    fr(32, {w[15:0], 16'h0});
    chk(rx[15:0], w[15:0]);
    $display("direct 16-bit test done");

    md(4'hc);
    live_status = '0;
    live_status.above_7v = 8'($urandom);
    for (int c = 0; c < 4; c++)
    begin
      rg[c] = $urandom % 256;
      fr(16, {17'h0, 7'(c), 8'(rg[c])});
    end
    lvl = 8'(rg[0]);
    pp = 8'(rg[1]);
    drv();
    chk(config_out, 8'(rg[3]));
    for (int n = 0; n < 5; n++)
    begin
      fr(16, {16'h0, 8'h20, 5'h0, 3'(n)});
      if (n == 0)
        chk(rx[15:0], {8'h00, live_status.above_7v});
      else
        chk(rx[15:0], {8'h00, 8'(rg[n - 1])});
    end
    $display("command test done");

    fr(16, 32'hb000);
    d = 8'($urandom) | 8'h01;
    live_status.open_load = d;
    live_status.global_fault = 1'b1;
    repeat (3) @(negedge sys_clk);
    live_status.open_load = 8'h00;
    live_status.global_fault = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(global_fault_n, 1'b0);
    fr(16, 32'h2004);
    fr(16, 32'hb000);
    chk(rx[15:0], {8'h00, d});
    chk(global_fault_n, 1'b1);
    fr(16, 32'h2004);
    fr(16, 32'h3000);
    chk(rx[15:0], 16'h0000);
    live_status.thermal = 8'h81;
    repeat (3) @(negedge sys_clk);
    live_status.thermal = 8'h00;
    fr(8, 32'h80);
    chk(frame_error, 1'b1);
    fr(16, 32'h2005);
    fr(16, 32'h3000);
    chk(rx[15:0], 16'h0081);
    $display("fault latch test done");

    md(4'h4);
    parallel_in = 8'($urandom);
    lvl = parallel_in;
    fr(16, {16'h0, 8'h00, ~parallel_in});
    drv();
    fr(16, {16'h0, 8'h01, ~pp});
    drv();
    parallel_config_allowed = 1'b1;
    fr(16, {16'h0, 8'h01, ~pp});
    pp = ~pp;
    drv();
    live_status.global_fault = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(global_fault_n, 1'b0);
    live_status.global_fault = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(global_fault_n, 1'b1);
    md(4'h0);
    fr(8, 32'h0f);
    chk(frame_error, 1'b1);
    chk(m.oe_bad, 0);
    $display("parallel test done");
    wrap_up();
  end
endmodule : octal_driver_spi_slave_tb
